// ==== aorc_regs.svh ====
// Register offsets, field positions and reset values of the audio output routing control
`ifndef AORC_REGS_SVH
`define AORC_REGS_SVH
`define AORC_ROUTING_CTRL_OFFSET          7'h21
`define AORC_NEIGHBOUR_CTRL_OFFSET        7'h20
`define AORC_BIT_FIRST_OUT_TO_LOUDSPEAKER 15
`define AORC_BIT_SIDETONE_TO_LOUDSPEAKER  14
`define AORC_BIT_BUZZER_TO_LOUDSPEAKER    13
`define AORC_BIT_KEYCLICK_TO_LOUDSPEAKER  12
`define AORC_BIT_CELL_INPUT_TO_LOUDSPEAKER 11
`define AORC_BIT_MIC_TO_CELL_OUTPUT       10
`define AORC_BIT_FIRST_OUT_TO_CELL_OUTPUT 9
`define AORC_BIT_SECOND_OUT_TO_CELL_OUTPUT 8
`define AORC_BIT_LOUDSPEAKER_MUTE         7
`define AORC_BIT_CELL_OUTPUT_MUTE         6
`define AORC_BIT_LOUDSPEAKER_PROTECT_DISABLE 5
`define AORC_BIT_VIRTUAL_GROUND_PROTECT_DISABLE 4
`define AORC_BIT_HEADSET_COUPLING_SELECT  3
`define AORC_WRITABLE_MASK                16'hFFF8
`define AORC_ROUTING_CTRL_RESET           16'h00E0
`endif

// ==== aorc_pkg.sv ====
// Types shared by the audio output routing control files
`default_nettype none
package aorc_pkg;
  typedef logic [15:0] aorc_word_t;
  typedef logic [6:0]  aorc_addr_t;
  typedef enum logic [1:0] {
    AORC_DAC_NONE,
    AORC_DAC_LEFT,
    AORC_DAC_RIGHT,
    AORC_DAC_AVERAGE
  } aorc_dac_sel_t;
  // One bit per analog source feeding an output summing node
  typedef struct packed {
    logic dac_left;
    logic dac_right;
    logic dac_average;
    logic sidetone;
    logic buzzer;
    logic keyclick;
    logic cell_input;
    logic microphone;
  } aorc_src_t;
endpackage
`default_nettype wire

// ==== aorc_dac_decode.sv ====
// Decoder of a two-bit DAC channel routing field into source enables
`timescale 1ns/1ps
`default_nettype none
module aorc_dac_decode (
  input  wire logic [1:0] dac_sel_i,
  output logic            dac_left_o,
  output logic            dac_right_o,
  output logic            dac_average_o
);
  import aorc_pkg::*;
  aorc_dac_sel_t sel;
  always_comb begin
    sel           = aorc_dac_sel_t'(dac_sel_i);
    dac_left_o    = 1'b0;
    dac_right_o   = 1'b0;
    dac_average_o = 1'b0;
    case (sel)
      AORC_DAC_NONE:    dac_left_o = 1'b0;
      AORC_DAC_LEFT:    dac_left_o = 1'b1;
      AORC_DAC_RIGHT:   dac_right_o = 1'b1;
      AORC_DAC_AVERAGE: dac_average_o = 1'b1;
      default:          dac_left_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ==== aorc_audio_output_routing_control.sv ====
// Audio output routing control register and the source enables it derives
//
// Operation
// - With the mirror bit set every first headset source also feeds the loudspeaker.
// - Four separate bits route sidetone, buzzer, keyclick and cell input to the loudspeaker.
// - The microphone bit routes the selected microphone to the cell-phone output.
// - The first-output bit sends first headset sources except cell input to the cell output.
// - Single-ended only, the second-output bit sends second headset sources to cell output.
// - The loudspeaker mute bit mutes the loudspeaker and resets to one.
// - The cell output mute bit mutes the cell output and resets to one.
// - A zero in the loudspeaker protection bit enables protection, and it resets to one.
// - A zero in the virtual-ground protection bit enables protection, and it resets to zero.
// - The coupling bit picks cap-less at zero and capacitor coupling at one; resets to zero.
// - The three lowest bits read as zero and the host writes zeros there.
// - The DAC routing field encodes none, left, right and average as 00, 01, 10, 11.
`timescale 1ns/1ps
`default_nettype none
`include "aorc_regs.svh"
module aorc_audio_output_routing_control (
  input  wire logic               ref_clk_i,
  input  wire logic               reset_n_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  input  wire aorc_pkg::aorc_addr_t reg_addr_i,
  input  wire aorc_pkg::aorc_word_t reg_wdata_i,
  output aorc_pkg::aorc_word_t    reg_rdata_o,
  output logic                    reg_hit_o,
  input  wire aorc_pkg::aorc_word_t first_out_ctrl_i,
  input  wire logic               differential_mode_i,
  output aorc_pkg::aorc_src_t     loudspeaker_output_src_o,
  output aorc_pkg::aorc_src_t     cell_phone_output_src_o,
  output logic                    loudspeaker_mute_o,
  output logic                    cell_output_mute_o,
  output logic                    loudspeaker_protect_enable_o,
  output logic                    virtual_ground_protect_enable_o,
  output logic                    headset_coupling_select_o
);
  import aorc_pkg::*;

  aorc_word_t ctrl_reg;
  aorc_word_t ctrl_next;
  aorc_word_t rdata_reg;
  aorc_word_t rdata_next;
  aorc_src_t  lsk_reg;
  aorc_src_t  lsk_next;
  aorc_src_t  cpo_reg;
  aorc_src_t  cpo_next;
  aorc_src_t  first_src;
  aorc_src_t  second_src;
  logic       hit;
  logic       first_l;
  logic       first_r;
  logic       first_a;
  logic       second_l;
  logic       second_r;
  logic       second_a;

  function automatic logic addr_match(input aorc_addr_t a);
    addr_match = (a == `AORC_ROUTING_CTRL_OFFSET);
  endfunction

  assign hit       = addr_match(reg_addr_i);
  assign reg_hit_o = hit;

  // Neighbouring register layout: first output fields 14..9, second 8..3
  aorc_dac_decode u_first_dec (
    .dac_sel_i     (first_out_ctrl_i[14:13]),
    .dac_left_o    (first_l),
    .dac_right_o   (first_r),
    .dac_average_o (first_a)
  );
  aorc_dac_decode u_second_dec (
    .dac_sel_i     (first_out_ctrl_i[8:7]),
    .dac_left_o    (second_l),
    .dac_right_o   (second_r),
    .dac_average_o (second_a)
  );

  always_comb begin
    first_src             = '0;
    first_src.dac_left    = first_l;
    first_src.dac_right   = first_r;
    first_src.dac_average = first_a;
    first_src.sidetone    = first_out_ctrl_i[12];
    first_src.buzzer      = first_out_ctrl_i[11];
    first_src.keyclick    = first_out_ctrl_i[10];
    first_src.cell_input  = first_out_ctrl_i[9];
    second_src             = '0;
    second_src.dac_left    = second_l;
    second_src.dac_right   = second_r;
    second_src.dac_average = second_a;
    second_src.sidetone    = first_out_ctrl_i[6];
    second_src.buzzer      = first_out_ctrl_i[5];
    second_src.keyclick    = first_out_ctrl_i[4];
    second_src.cell_input  = first_out_ctrl_i[3];
  end

  // Register write and read path
  always_comb begin
    ctrl_next  = ctrl_reg;
    rdata_next = rdata_reg;
    if (reg_wr_i && hit) begin
      ctrl_next = reg_wdata_i & `AORC_WRITABLE_MASK;
    end
    if (reg_rd_i && hit) begin
      rdata_next = ctrl_reg & `AORC_WRITABLE_MASK;
    end else if (reg_rd_i) begin
      rdata_next = '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_reg  <= `AORC_ROUTING_CTRL_RESET;
      rdata_reg <= 16'h0000;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  // Source routing, registered so outputs change two edges after a write
  always_comb begin
    lsk_next = '0;
    if (ctrl_reg[`AORC_BIT_FIRST_OUT_TO_LOUDSPEAKER]) begin
      lsk_next = first_src;
    end
    lsk_next.sidetone   = lsk_next.sidetone |
                          ctrl_reg[`AORC_BIT_SIDETONE_TO_LOUDSPEAKER];
    lsk_next.buzzer     = lsk_next.buzzer |
                          ctrl_reg[`AORC_BIT_BUZZER_TO_LOUDSPEAKER];
    lsk_next.keyclick   = lsk_next.keyclick |
                          ctrl_reg[`AORC_BIT_KEYCLICK_TO_LOUDSPEAKER];
    lsk_next.cell_input = lsk_next.cell_input |
                          ctrl_reg[`AORC_BIT_CELL_INPUT_TO_LOUDSPEAKER];
    cpo_next = '0;
    cpo_next.microphone = ctrl_reg[`AORC_BIT_MIC_TO_CELL_OUTPUT];
    if (ctrl_reg[`AORC_BIT_FIRST_OUT_TO_CELL_OUTPUT]) begin
      // Cell input excluded to avoid a loop back to the phone
      cpo_next.dac_left    = first_src.dac_left;
      cpo_next.dac_right   = first_src.dac_right;
      cpo_next.dac_average = first_src.dac_average;
      cpo_next.sidetone    = first_src.sidetone;
      cpo_next.buzzer      = first_src.buzzer;
      cpo_next.keyclick    = first_src.keyclick;
    end
    // Second output has no meaning in differential mode; host
    if (ctrl_reg[`AORC_BIT_SECOND_OUT_TO_CELL_OUTPUT] && !differential_mode_i) begin
      cpo_next = cpo_next | second_src;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lsk_reg <= '0;
      cpo_reg <= '0;
    end else begin
      lsk_reg <= lsk_next;
      cpo_reg <= cpo_next;
    end
  end

  assign reg_rdata_o                     = rdata_reg;
  assign loudspeaker_output_src_o        = lsk_reg;
  assign cell_phone_output_src_o         = cpo_reg;
  assign loudspeaker_mute_o              = ctrl_reg[`AORC_BIT_LOUDSPEAKER_MUTE];
  assign cell_output_mute_o              = ctrl_reg[`AORC_BIT_CELL_OUTPUT_MUTE];
  assign loudspeaker_protect_enable_o    =
    ~ctrl_reg[`AORC_BIT_LOUDSPEAKER_PROTECT_DISABLE];
  assign virtual_ground_protect_enable_o =
    ~ctrl_reg[`AORC_BIT_VIRTUAL_GROUND_PROTECT_DISABLE];
  assign headset_coupling_select_o       = ctrl_reg[`AORC_BIT_HEADSET_COUPLING_SELECT];
endmodule
`default_nettype wire

// ==== aorc_routing_chk.sv ====
// Port-level assertions for the routing control register
`timescale 1ns/1ps
`default_nettype none
module aorc_routing_chk (
  input wire logic                 ref_clk_i,
  input wire logic                 reset_n_i,
  input wire logic                 reg_wr_i,
  input wire logic                 reg_rd_i,
  input wire aorc_pkg::aorc_addr_t reg_addr_i,
  input wire aorc_pkg::aorc_word_t reg_wdata_i,
  input wire aorc_pkg::aorc_word_t reg_rdata_o,
  input wire logic                 reg_hit_o,
  input wire aorc_pkg::aorc_word_t first_out_ctrl_i,
  input wire logic                 differential_mode_i,
  input wire aorc_pkg::aorc_src_t  loudspeaker_output_src_o,
  input wire aorc_pkg::aorc_src_t  cell_phone_output_src_o,
  input wire logic                 loudspeaker_mute_o,
  input wire logic                 cell_output_mute_o,
  input wire logic                 loudspeaker_protect_enable_o,
  input wire logic                 virtual_ground_protect_enable_o,
  input wire logic                 headset_coupling_select_o
);
  import aorc_pkg::*;
  wire logic wr_hit = reg_wr_i && reg_hit_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  lsk_mute_a: assert property (wr_hit |=> loudspeaker_mute_o == $past(reg_wdata_i[7]))
    else $error("loudspeaker mute wrong");
  cell_mute_a: assert property (wr_hit |=> cell_output_mute_o == $past(reg_wdata_i[6]))
    else $error("cell mute wrong");
  lsk_protect_a: assert property (wr_hit |=>
    loudspeaker_protect_enable_o != $past(reg_wdata_i[5])) else $error("loudspeaker protect wrong");
  virtual_ground_driver_protect_a: assert property (wr_hit |=>
    virtual_ground_protect_enable_o != $past(reg_wdata_i[4])) else $error("ground protect wrong");
  coupling_sel_a: assert property (wr_hit |=>
    headset_coupling_select_o == $past(reg_wdata_i[3])) else $error("coupling select wrong");
  hit_decode_a: assert property (reg_hit_o == (reg_addr_i == 7'h21))
    else $error("address decode wrong");
  reserved_zero_a: assert property (reg_rdata_o[2:0] == 3'h0)
    else $error("reserved bits not zero");
  unmapped_read_a: assert property (reg_rd_i && !reg_hit_o |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  read_back_a: assert property ((wr_hit ##1 (reg_rd_i && reg_hit_o && !reg_wr_i))
    |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 16'hFFF8)) else $error("read back wrong");
endmodule
`default_nettype wire

// ==== aorc_host_model.sv ====
// Host model driving the register strobe bus
`timescale 1ns/1ps
`default_nettype none
module aorc_host_model (
  input  wire logic                 ref_clk_i,
  input  wire aorc_pkg::aorc_word_t reg_rdata_i,
  output logic                      reg_wr_o,
  output logic                      reg_rd_o,
  output aorc_pkg::aorc_addr_t      reg_addr_o,
  output aorc_pkg::aorc_word_t      reg_wdata_o
);
  import aorc_pkg::*;
  initial begin
    {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = '0;
  end
  task automatic acc(input logic w, input aorc_addr_t a, input aorc_word_t d,
                     output aorc_word_t q);
    @(negedge ref_clk_i);
    {reg_wr_o, reg_rd_o, reg_addr_o} = {w, !w, a};
    reg_wdata_o = d & 16'hFFF8;
    @(negedge ref_clk_i);
    q = reg_rdata_i;
    {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {2'b00, ~a, ~d};
  endtask
  // Write followed at once by a read of the same address
  task automatic wr_rd(input aorc_addr_t a, input aorc_word_t d, output aorc_word_t q);
    @(negedge ref_clk_i);
    {reg_wr_o, reg_rd_o, reg_addr_o} = {2'b10, a};
    reg_wdata_o = d & 16'hFFF8;
    @(negedge ref_clk_i);
    {reg_wr_o, reg_rd_o} = 2'b01;
    @(negedge ref_clk_i);
    q = reg_rdata_i;
    {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {2'b00, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the routing control register
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import aorc_pkg::*;
  logic       ref_clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       wr, rd, diff, hit, lm, cm, lp, vp, cs;
  aorc_addr_t addr;
  aorc_word_t wdata, rdata, fctl, q;
  aorc_src_t  ls, cp;
  int         failures = 0;
  int         num_checks = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  aorc_host_model aorc_host_model_inst (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata));
  aorc_audio_output_routing_control aorc_audio_output_routing_control_inst (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_hit_o(hit),
    .first_out_ctrl_i(fctl), .differential_mode_i(diff), .loudspeaker_output_src_o(ls),
    .cell_phone_output_src_o(cp), .loudspeaker_mute_o(lm), .cell_output_mute_o(cm),
    .loudspeaker_protect_enable_o(lp), .virtual_ground_protect_enable_o(vp),
    .headset_coupling_select_o(cs));
  function automatic logic [2:0] dac(input logic [1:0] s);
    return {s == 2'h1, s == 2'h2, s == 2'h3};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check_all(input aorc_word_t c);
    aorc_src_t s1, s2;
    s1 = {dac(fctl[14:13]), fctl[12:9], 1'b0};
    s2 = {dac(fctl[8:7]), fctl[6:3], 1'b0};
    repeat (2) @(negedge ref_clk_i);
    chk({lm, cm}, {c[7], c[6]});
    chk({lp, vp, cs}, {~c[5], ~c[4], c[3]});
    chk(ls, {3'h0, c[14:11], 1'b0} | (c[15] ? s1 : 8'h00));
    chk(cp, {7'h0, c[10]} | (c[9] ? s1 & 8'hFD : 8'h00) |
        (c[8] && !diff ? s2 : 8'h00));
    aorc_host_model_inst.acc(1'b0, 7'h21, 16'h0000, q);
    chk(q, c & 16'hFFF8);
  endtask
  initial begin
    {diff, fctl} = '0;
    repeat (10) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    check_all(16'h00E0);
    fctl = 16'h7FF8;
    for (int i = 3; i < 16; i++) begin
      aorc_host_model_inst.acc(1'b1, 7'h21, 16'h0001 << i, q);
      check_all(16'h0001 << i);
    end
    for (int k = 0; k < 4; k++) begin
      fctl = {1'b0, k[1:0], 4'hA, 2'(3 - k), 4'h5, 3'h0};
      diff = k[0];
      q = k[0] ? 16'h0700 : 16'h86FF;
      aorc_host_model_inst.acc(1'b1, 7'h21, q, q);
      check_all(k[0] ? 16'h0700 : 16'h86F8);
    end
    aorc_host_model_inst.acc(1'b1, 7'h20, 16'h0038, q);
    aorc_host_model_inst.acc(1'b0, 7'h20, 16'h0000, q);
    chk(q, 16'h0000);
    check_all(16'h0700);
    aorc_host_model_inst.wr_rd(7'h21, 16'h5A5F, q);
    chk(q, 16'h5A58);
    check_all(16'h5A58);
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    failures++;
    give_verdict();
  end
endmodule
bind aorc_audio_output_routing_control aorc_routing_chk aorc_routing_chk_inst (
  .ref_clk_i                       (ref_clk_i),
  .reset_n_i                       (reset_n_i),
  .reg_wr_i                        (reg_wr_i),
  .reg_rd_i                        (reg_rd_i),
  .reg_addr_i                      (reg_addr_i),
  .reg_wdata_i                     (reg_wdata_i),
  .reg_rdata_o                     (reg_rdata_o),
  .reg_hit_o                       (reg_hit_o),
  .first_out_ctrl_i                (first_out_ctrl_i),
  .differential_mode_i             (differential_mode_i),
  .loudspeaker_output_src_o        (loudspeaker_output_src_o),
  .cell_phone_output_src_o         (cell_phone_output_src_o),
  .loudspeaker_mute_o              (loudspeaker_mute_o),
  .cell_output_mute_o              (cell_output_mute_o),
  .loudspeaker_protect_enable_o    (loudspeaker_protect_enable_o),
  .virtual_ground_protect_enable_o (virtual_ground_protect_enable_o),
  .headset_coupling_select_o       (headset_coupling_select_o)
);
`default_nettype wire
